// file: shared/sram_link_pkg.sv
// Shared widths, link timing and latency constants for the burst-of-two SRAM link
package sram_link_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W_DEF = 20;                    // Burst address width
  localparam int DATA_W_DEF = 36;                    // Word width
  localparam int BYTE_W_DEF = 9;                     // Bits per byte lane
  localparam int NBYTE_DEF  = DATA_W_DEF / BYTE_W_DEF;

  // ****************************************
  // Link clock timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;                // System clock period
  localparam int K_PERIOD_NS   = 800;                // Main link clock period
  localparam int K_HALF_CYC    = K_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int K_DIV_CYC     = 2 * K_HALF_CYC;
  // Divider counts on which the controller changes its pins
  localparam logic [3:0] DIV_LAST     = 4'(K_DIV_CYC - 1);
  localparam logic [3:0] DIV_FALL     = 4'(K_HALF_CYC - 1);
  localparam logic [3:0] DIV_SET_RISE = 4'(K_DIV_CYC - 3);
  localparam logic [3:0] DIV_SET_FALL = 4'(K_HALF_CYC - 3);

  // ****************************************
  // Read latency in half-cycle ticks
  // ****************************************
  localparam logic [2:0] LAT_TICKS_LONG  = 3'h4;     // 2.0 cycles
  localparam logic [2:0] LAT_TICKS_SHORT = 3'h2;     // 1 cycle

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic SLOT_RESET = 1'b0;                // First main rising edge is a read slot

  // Controller read capture states
  typedef enum logic {
    CAP_WORD0 = 1'b0,
    CAP_WORD1 = 1'b1
  } cap_state_t;

endpackage

// file: shared/sram_link_if.sv
// Pin bundle between the memory controller and the SRAM
`timescale 1ns/100ps
interface sram_link_if;
  import sram_link_pkg::*;

  // Clocks from the controller
  logic                  k;
  logic                  k_n;
  // Address and selects
  logic [ADDR_W_DEF-1:0] addr;
  logic                  rd_sel_n;
  logic                  wr_sel_n;
  logic                  latency_select_pin;
  // Write port
  logic [DATA_W_DEF-1:0] wr_data;
  logic [NBYTE_DEF-1:0]  byte_write_select_n;
  // Read port
  logic [DATA_W_DEF-1:0] rd_data;
  logic                  output_valid_flag;
  logic                  echo_clock_out;
  logic                  echo_clock_out_n;

  modport dev (
    input  k, k_n, addr, rd_sel_n, wr_sel_n, latency_select_pin, wr_data, byte_write_select_n,
    output rd_data, output_valid_flag, echo_clock_out, echo_clock_out_n
  );

  modport ctl (
    output k, k_n, addr, rd_sel_n, wr_sel_n, latency_select_pin, wr_data, byte_write_select_n,
    input  rd_data, output_valid_flag, echo_clock_out, echo_clock_out_n
  );
endinterface

// file: hw/sram_dev_end.sv
// Memory end: dual-port burst-of-two DDR SRAM behind the shared link
`timescale 1ns/100ps
// ****************************************
// Notes on behaviour
// [RULE1] Separate read and write ports run concurrently
// [RULE2] One address bus serves both ports
// [RULE3] Read and write addresses alternate main edges
// [RULE4] Each address holds two sequential words
// [RULE5] Words move on both clocks' rising edges
// [RULE6] Latency pin high: 2.0 cycle read latency
// [RULE7] Latency pin low: 1 cycle read latency
// [RULE8] Valid flag high while read data shown
// [RULE9] Complementary echo clocks follow read data
// [RULE10] Each port has its own select
// [RULE11] Inputs captured by main clock edges
// [RULE12] Data outputs come from registers
// [RULE13] Writes complete internally, self-timed
// [RULE14] Reads return newest data, even in-flight
// [RULE15] Byte selects sampled with write words
// [RULE16] Deselected port idles, other unaffected
// [RULE17] Controller holds latency pin constant
// ****************************************
module sram_dev_end
  import sram_link_pkg::*;
#(
  parameter int MEM_AW = ADDR_W_DEF
) (
  // System
  input  wire logic clk,
  input  wire logic rst_b,
  // Link
  sram_link_if.dev  lnk,
  // Activity
  output logic      wr_done,
  output logic      rd_done
);

  localparam int AW    = ADDR_W_DEF;
  localparam int DW    = DATA_W_DEF;
  localparam int NB    = NBYTE_DEF;
  localparam int BW    = BYTE_W_DEF;
  localparam int IN_W  = 2 + AW + 2 + DW + NB + 1;
  localparam int DEPTH = 2 ** (MEM_AW + 1);
  // Idle pin levels, so no false true-clock edge or select follows reset
  localparam logic [IN_W-1:0] IN_IDLE = {1'b0, 1'b1, {AW{1'b0}}, 2'b11, {DW{1'b0}}, {NB{1'b1}}, 1'b1};

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [IN_W-1:0]   in_s1_r;
  logic [IN_W-1:0]   in_s2_r;
  logic              k_s3_r;
  logic              kn_s3_r;
  logic              k_s;
  logic              kn_s;
  logic [AW-1:0]     addr_s;
  logic              rsel_n_s;
  logic              wsel_n_s;
  logic [DW-1:0]     d_s;
  logic [NB-1:0]     bw_n_s;
  logic              lat_s;
  logic              rk;
  logic              rkn;
  logic              tick;

  // Two flops on every pin, clocks included
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_s1_r <= IN_IDLE;
      in_s2_r <= IN_IDLE;
    end else begin
      in_s1_r <= {lnk.k, lnk.k_n, lnk.addr, lnk.rd_sel_n, lnk.wr_sel_n,
                  lnk.wr_data, lnk.byte_write_select_n, lnk.latency_select_pin};
      in_s2_r <= in_s1_r;
    end
  end

  assign {k_s, kn_s, addr_s, rsel_n_s, wsel_n_s, d_s, bw_n_s, lat_s} = in_s2_r;

  // Edge history for the two main clocks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      k_s3_r  <= 1'b0;
      kn_s3_r <= 1'b0;
    end else begin
      k_s3_r  <= k_s;
      kn_s3_r <= kn_s;
    end
  end

  // Only rising edges matter; each is one half-cycle tick
  assign rk   = k_s & ~k_s3_r;   // RULE5
  assign rkn  = kn_s & ~kn_s3_r; // RULE5
  assign tick = rk | rkn;

  // ****************************************
  // Address slot tracking
  // ****************************************
  logic slot_wr_r;

  // Slots alternate on true-clock rising edges, read first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slot_wr_r <= SLOT_RESET;
    end else if (rk) begin
      slot_wr_r <= ~slot_wr_r; // RULE3
    end
  end

  // ****************************************
  // Byte merge
  // ****************************************
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
                                          input logic [NB-1:0] bwn);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < NB; i++) begin
      if (!bwn[i]) begin
        res[i*BW +: BW] = new_w[i*BW +: BW];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Write port
  // ****************************************
  logic [MEM_AW-1:0] wadr_r;
  logic              w1_pend_r;
  logic              wr_go;
  logic              wr_en;
  logic [MEM_AW:0]   wr_idx;
  logic [DW-1:0]     mem_r [DEPTH];

  // Write address and first word share the write slot edge
  assign wr_go  = rk & slot_wr_r & ~wsel_n_s;              // RULE2 RULE3 RULE10 RULE16
  assign wr_en  = wr_go | (rkn & w1_pend_r);               // RULE4 RULE5
  assign wr_idx = wr_go ? {addr_s[MEM_AW-1:0], 1'b0} : {wadr_r, 1'b1};

  // Hold the burst address for the second word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wadr_r    <= '0;
      w1_pend_r <= 1'b0;
    end else if (wr_go) begin
      wadr_r    <= addr_s[MEM_AW-1:0]; // RULE11
      w1_pend_r <= 1'b1;
    end else if (rkn) begin
      w1_pend_r <= 1'b0;
    end
  end

  // Array update, one word per edge, byte lanes masked
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= merge(mem_r[wr_idx], d_s, bw_n_s); // RULE13 RULE15
    end
  end

  // Pulse once per completed burst
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= rkn & w1_pend_r;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [MEM_AW-1:0] radr_r;
  logic [MEM_AW-1:0] oadr_r;
  logic [2:0]        cnt_r;
  logic              r1_pend_r;
  logic              rd_go;
  logic              fire;
  logic [MEM_AW:0]   rd_idx;
  logic [DW-1:0]     rd_word;

  assign rd_go  = rk & ~slot_wr_r & ~rsel_n_s;   // RULE2 RULE3 RULE10 RULE16
  assign fire   = tick & (cnt_r == 3'h1);
  assign rd_idx = fire ? {radr_r, 1'b0} : {oadr_r, 1'b1};

  // Forward a word being written in this very cycle
  assign rd_word = (wr_en && wr_idx == rd_idx) ? merge(mem_r[rd_idx], d_s, bw_n_s)
                                               : mem_r[rd_idx]; // RULE14

  // Latency countdown in half-cycle ticks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      radr_r <= '0;
      cnt_r  <= '0;
    end else if (rd_go) begin
      radr_r <= addr_s[MEM_AW-1:0];                            // RULE11
      cnt_r  <= lat_s ? LAT_TICKS_LONG : LAT_TICKS_SHORT;      // RULE6 RULE7
    end else if (tick && cnt_r != 3'h0) begin
      cnt_r  <= cnt_r - 3'h1;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [DW-1:0] dout_r;
  logic          valid_r;
  logic          echo_r;

  // Two words out on consecutive ticks, valid around them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dout_r    <= '0;
      valid_r   <= 1'b0;
      r1_pend_r <= 1'b0;
      oadr_r    <= '0;
    end else if (fire) begin
      dout_r    <= rd_word;      // RULE4 RULE12
      valid_r   <= 1'b1;         // RULE8
      r1_pend_r <= 1'b1;
      oadr_r    <= radr_r;
    end else if (tick && r1_pend_r) begin
      dout_r    <= rd_word;      // RULE4 RULE12
      r1_pend_r <= 1'b0;
    end else if (tick) begin
      valid_r   <= 1'b0;         // RULE8
    end
  end

  // Echo follows the sampled main clock, same stage as the data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      echo_r  <= 1'b0;
      rd_done <= 1'b0;
    end else begin
      echo_r  <= k_s;                      // RULE9
      rd_done <= tick & r1_pend_r;
    end
  end

  // Read and write paths share the array, the slot flag and the forwarding of in-flight write words
  assign lnk.rd_data           = dout_r;  // RULE1 RULE12
  assign lnk.output_valid_flag = valid_r;
  assign lnk.echo_clock_out    = echo_r;  // RULE9
  assign lnk.echo_clock_out_n  = ~echo_r; // RULE9

endmodule

// file: hw/sram_ctl_end.sv
// Controller end: makes the link clocks and runs read and write bursts
`timescale 1ns/100ps
module sram_ctl_end
  import sram_link_pkg::*;
(
  // System
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Configuration
  input  wire logic                  lat_cfg,
  // Read requests
  input  wire logic                  rd_req,
  input  wire logic [ADDR_W_DEF-1:0] rd_addr,
  output logic                       rd_ready,
  output logic                       rd_valid,
  output logic [DATA_W_DEF-1:0]      rd_data0,
  output logic [DATA_W_DEF-1:0]      rd_data1,
  // Write requests
  input  wire logic                  wr_req,
  input  wire logic [ADDR_W_DEF-1:0] wr_addr,
  input  wire logic [DATA_W_DEF-1:0] wr_data0,
  input  wire logic [DATA_W_DEF-1:0] wr_data1,
  input  wire logic [NBYTE_DEF-1:0]  wr_be0,
  input  wire logic [NBYTE_DEF-1:0]  wr_be1,
  output logic                       wr_ready,
  // Link
  sram_link_if.ctl                   lnk
);

  localparam int AW   = ADDR_W_DEF;
  localparam int DW   = DATA_W_DEF;
  localparam int NB   = NBYTE_DEF;
  localparam int CP_W = 3 + DW;

  // ****************************************
  // Link clock divider and slot phase
  // ****************************************
  logic [3:0] div_r;
  logic       k_r;
  logic       slot_wr_r;
  logic       lat_r;
  logic       cfg_done_r;

  // Main clock from a register, its complement the inverse of that register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r     <= '0;
      k_r       <= 1'b0;
      slot_wr_r <= SLOT_RESET;
    end else begin
      div_r <= (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
      if (div_r == DIV_LAST) begin
        k_r       <= 1'b1;
        slot_wr_r <= ~slot_wr_r; // RULE3
      end else if (div_r == DIV_FALL) begin
        k_r <= 1'b0;
      end
    end
  end

  // Latency level taken once after reset and then held
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lat_r      <= 1'b1;
      cfg_done_r <= 1'b0;
    end else if (!cfg_done_r) begin
      lat_r      <= lat_cfg; // RULE17
      cfg_done_r <= 1'b1;
    end
  end

  // ****************************************
  // Request holding
  // ****************************************
  logic          rd_pend_r;
  logic          rd_out_r;
  logic [AW-1:0] rq_radr_r;
  logic          wr_pend_r;
  logic          wr_second_r;
  logic [AW-1:0] rq_wadr_r;
  logic [DW-1:0] wd0_r;
  logic [DW-1:0] wd1_r;
  logic [NB-1:0] be0_r;
  logic [NB-1:0] be1_r;
  logic          set_rise;
  logic          set_fall;
  logic          rd_issue;
  logic          wr_issue;
  logic          burst_done;

  assign rd_ready = ~rd_pend_r & ~rd_out_r;
  assign wr_ready = ~wr_pend_r & ~wr_second_r;
  assign set_rise = (div_r == DIV_SET_RISE);
  assign set_fall = (div_r == DIV_SET_FALL);
  // The slot flag flips at the coming rise, so low means a read slot
  assign rd_issue = set_rise & ~slot_wr_r & rd_pend_r;
  assign wr_issue = set_rise & slot_wr_r & wr_pend_r;

  // Read request held until its slot, then until data returns
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_pend_r <= 1'b0;
      rd_out_r  <= 1'b0;
      rq_radr_r <= '0;
    end else begin
      if (rd_req && rd_ready) begin
        rd_pend_r <= 1'b1;
        rq_radr_r <= rd_addr;
      end else if (rd_issue) begin
        rd_pend_r <= 1'b0;
        rd_out_r  <= 1'b1;
      end else if (burst_done) begin
        rd_out_r  <= 1'b0;
      end
    end
  end

  // Write request held until both words have gone out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r   <= 1'b0;
      wr_second_r <= 1'b0;
      rq_wadr_r   <= '0;
      wd0_r       <= '0;
      wd1_r       <= '0;
      be0_r       <= '0;
      be1_r       <= '0;
    end else if (wr_req && wr_ready) begin
      wr_pend_r <= 1'b1;
      rq_wadr_r <= wr_addr;
      wd0_r     <= wr_data0;
      wd1_r     <= wr_data1;
      be0_r     <= wr_be0;
      be1_r     <= wr_be1;
    end else if (wr_issue) begin
      wr_pend_r   <= 1'b0;
      wr_second_r <= 1'b1;
    end else if (set_fall) begin
      wr_second_r <= 1'b0;
    end
  end

  // ****************************************
  // Pin drive, mid-way between edges
  // ****************************************
  logic [AW-1:0] addr_r;
  logic          rsel_n_r;
  logic          wsel_n_r;
  logic [DW-1:0] d_r;
  logic [NB-1:0] bw_n_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_r   <= '0;
      rsel_n_r <= 1'b1;
      wsel_n_r <= 1'b1;
      d_r      <= '0;
      bw_n_r   <= '1;
    end else if (set_rise) begin
      rsel_n_r <= ~rd_issue;                       // RULE10
      wsel_n_r <= ~wr_issue;                       // RULE10
      if (rd_issue) begin
        addr_r <= rq_radr_r;                       // RULE2 RULE3
      end else if (wr_issue) begin
        addr_r <= rq_wadr_r;                       // RULE2 RULE3
        d_r    <= wd0_r;                           // RULE4
        bw_n_r <= ~be0_r;                          // RULE15
      end
    end else if (set_fall) begin
      rsel_n_r <= 1'b1;
      wsel_n_r <= 1'b1;
      if (wr_second_r) begin
        d_r    <= wd1_r;                           // RULE4 RULE5
        bw_n_r <= ~be1_r;                          // RULE15
      end
    end
  end

  assign lnk.k                   = k_r;
  assign lnk.k_n                 = ~k_r;
  assign lnk.addr                = addr_r;
  assign lnk.rd_sel_n            = rsel_n_r;
  assign lnk.wr_sel_n            = wsel_n_r;
  assign lnk.wr_data             = d_r;
  assign lnk.byte_write_select_n = bw_n_r;
  assign lnk.latency_select_pin  = lat_r;          // RULE17

  // ****************************************
  // Read capture on echo clocks
  // ****************************************
  logic [CP_W-1:0] cp_s1_r;
  logic [CP_W-1:0] cp_s2_r;
  logic            e_s3_r;
  logic            e_s;
  logic            en_s;
  logic            v_s;
  logic [DW-1:0]   q_s;
  logic            e_edge;
  cap_state_t      cap_r;

  // Two flops on returning pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cp_s1_r <= '0;
      cp_s2_r <= '0;
      e_s3_r  <= 1'b0;
    end else begin
      cp_s1_r <= {lnk.echo_clock_out, lnk.echo_clock_out_n, lnk.output_valid_flag, lnk.rd_data};
      cp_s2_r <= cp_s1_r;
      e_s3_r  <= e_s;
    end
  end

  assign {e_s, en_s, v_s, q_s} = cp_s2_r;
  // A rising edge of either echo clock is a change of the true one
  assign e_edge     = (e_s & ~e_s3_r) | (en_s & e_s3_r);
  assign burst_done = e_edge & v_s & (cap_r == CAP_WORD1);

  // Pair the two words of a burst
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_r    <= CAP_WORD0;
      rd_data0 <= '0;
      rd_data1 <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= burst_done;
      if (e_edge && v_s) begin
        unique case (cap_r)
          CAP_WORD0: begin
            rd_data0 <= q_s;                       // RULE9
            cap_r    <= CAP_WORD1;
          end
          CAP_WORD1: begin
            rd_data1 <= q_s;                       // RULE9
            cap_r    <= CAP_WORD0;
          end
        endcase
      end
    end
  end

endmodule

// file: tb/sram_link_assertions.sv
// Protocol checker for the link between the controller end and the memory end
`timescale 1ns/100ps
module sram_link_assertions
  import sram_link_pkg::*;
(
  // System
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Link pins
  input  wire logic                  k,
  input  wire logic                  k_n,
  input  wire logic                  rd_sel_n,
  input  wire logic                  wr_sel_n,
  input  wire logic                  latency_select_pin,
  input  wire logic [DATA_W_DEF-1:0] rd_data,
  input  wire logic                  output_valid_flag,
  input  wire logic                  echo_clock_out,
  input  wire logic                  echo_clock_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [4:0] sel_age_r;

  // Cycles since the read select was last low, saturating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_age_r <= 5'h1F;
    end else if (!rd_sel_n) begin
      sel_age_r <= 5'h00;
    end else if (sel_age_r != 5'h1F) begin
      sel_age_r <= sel_age_r + 5'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_k_pair;
    $rose(k) |-> (k && !k_n)[*4] ##1 (!k && k_n)[*4] ##1 k;
  endproperty
  property p_echo_pair;
    $changed(k) |-> ##3 ($changed(echo_clock_out) && echo_clock_out_n == ~echo_clock_out);
  endproperty
  property p_valid_len;
    $rose(output_valid_flag) |-> output_valid_flag[*8] ##1 !output_valid_flag;
  endproperty
  property p_data_in_valid;
    $changed(rd_data) |-> output_valid_flag;
  endproperty
  property p_echo_with_data;
    $changed(rd_data) |-> $changed(echo_clock_out);
  endproperty
  property p_lat_long;
    $rose(k) && !rd_sel_n && latency_select_pin |-> ##[17:21] $rose(output_valid_flag);
  endproperty
  property p_lat_short;
    $rose(k) && !rd_sel_n && !latency_select_pin |-> ##[9:13] $rose(output_valid_flag);
  endproperty
  property p_no_read_no_valid;
    $rose(output_valid_flag) |-> sel_age_r <= 5'h14;
  endproperty
  property p_sel_apart;
    !(!rd_sel_n && !wr_sel_n);
  endproperty
  property p_wr_burst;
    $fell(wr_sel_n) |-> !wr_sel_n[*4] ##1 wr_sel_n;
  endproperty

  a_k_pair:           assert property (p_k_pair) else $error("k_n not inverse of k");
  a_echo_pair:        assert property (p_echo_pair) else $error("echo pair not complementary");
  a_valid_len:        assert property (p_valid_len) else $error("valid flag wrong length");
  a_data_in_valid:    assert property (p_data_in_valid) else $error("read data moved outside valid");
  a_echo_with_data:   assert property (p_echo_with_data) else $error("echo not aligned with data");
  a_lat_long:         assert property (p_lat_long) else $error("long read latency wrong");
  a_lat_short:        assert property (p_lat_short) else $error("short read latency wrong");
  a_no_read_no_valid: assert property (p_no_read_no_valid) else $error("valid without read select");
  a_sel_apart:        assert property (p_sel_apart) else $error("both selects low at once");
  a_wr_burst:         assert property (p_wr_burst) else $error("write select window wrong");

  // Main scenarios reached
  c_long:  cover property ($rose(output_valid_flag) && latency_select_pin);
  c_short: cover property ($rose(output_valid_flag) && !latency_select_pin);
  c_write: cover property ($fell(wr_sel_n));
endmodule

// file: tb/dual_port_ddr_burst2_sram_interface_tb_top.sv
// Self-checking bench joining the controller end and the memory end
`timescale 1ns/100ps
module dual_port_ddr_burst2_sram_interface_tb_top
  import sram_link_pkg::*;
;
  logic                  clk;
  logic                  rst_b;
  logic                  lat_cfg;
  logic                  rd_req;
  logic [ADDR_W_DEF-1:0] rd_addr;
  logic                  rd_ready;
  logic                  rd_valid;
  logic [DATA_W_DEF-1:0] rd_data0;
  logic [DATA_W_DEF-1:0] rd_data1;
  logic                  wr_req;
  logic [ADDR_W_DEF-1:0] wr_addr;
  logic [DATA_W_DEF-1:0] wr_data0;
  logic [DATA_W_DEF-1:0] wr_data1;
  logic [NBYTE_DEF-1:0]  wr_be0;
  logic [NBYTE_DEF-1:0]  wr_be1;
  logic                  wr_ready;
  logic                  wr_done;
  logic                  rd_done;
  logic [DATA_W_DEF-1:0] d0;
  logic [DATA_W_DEF-1:0] d1;
  logic [DATA_W_DEF-1:0] e0;
  logic [DATA_W_DEF-1:0] e1;
  int                    failures;
  int                    n_compared;
  int                    n_wr;
  int                    n_rd;
  int                    n_vld;
  int                    snap;

  // ****************************************
  // Ends, link and checker
  // ****************************************
  sram_link_if lnk ();
  sram_ctl_end i_sram_ctl_end (.clk(clk), .rst_b(rst_b), .lat_cfg(lat_cfg), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_be0(wr_be0), .wr_be1(wr_be1),
    .wr_ready(wr_ready), .lnk(lnk.ctl));
  sram_dev_end #(.MEM_AW(4)) i_sram_dev_end (.clk(clk), .rst_b(rst_b), .lnk(lnk.dev), .wr_done(wr_done),
    .rd_done(rd_done));
  sram_link_assertions i_sram_link_assertions (.clk(clk), .rst_b(rst_b), .k(lnk.k), .k_n(lnk.k_n),
    .rd_sel_n(lnk.rd_sel_n), .wr_sel_n(lnk.wr_sel_n), .latency_select_pin(lnk.latency_select_pin),
    .rd_data(lnk.rd_data), .output_valid_flag(lnk.output_valid_flag), .echo_clock_out(lnk.echo_clock_out),
    .echo_clock_out_n(lnk.echo_clock_out_n));

  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Activity counters on the memory end
  always @(posedge clk) begin
    if (rst_b === 1'b1 && wr_done === 1'b1) n_wr++;
    if (rst_b === 1'b1 && rd_done === 1'b1) n_rd++;
    if (rst_b === 1'b1 && lnk.output_valid_flag === 1'b1) n_vld++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [DATA_W_DEF-1:0] seen, input logic [DATA_W_DEF-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [DATA_W_DEF-1:0] merge(logic [DATA_W_DEF-1:0] old, logic [DATA_W_DEF-1:0] nw,
                                                  logic [NBYTE_DEF-1:0] be);
    for (int i = 0; i < NBYTE_DEF; i++) begin
      if (be[i]) old[9*i +: 9] = nw[9*i +: 9];
    end
    return old;
  endfunction

  // Write burst, returns once the second word is on the link
  task automatic wr(input logic [ADDR_W_DEF-1:0] a, input logic [DATA_W_DEF-1:0] x0, input logic [DATA_W_DEF-1:0] x1,
                    input logic [NBYTE_DEF-1:0] b0, input logic [NBYTE_DEF-1:0] b1);
    repeat (100) if (wr_ready !== 1'b1) @(negedge clk);
    wr_req   = 1'b1;
    wr_addr  = a;
    wr_data0 = x0;
    wr_data1 = x1;
    wr_be0   = b0;
    wr_be1   = b1;
    @(negedge clk);
    wr_req = 1'b0;
    repeat (100) if (wr_ready !== 1'b1) @(negedge clk);
    check(wr_ready, 1'b1);
  endtask

  // Read burst, leaves both words in d0 and d1
  task automatic rd(input logic [ADDR_W_DEF-1:0] a);
    repeat (100) if (rd_ready !== 1'b1) @(negedge clk);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_req = 1'b0;
    repeat (100) if (rd_valid !== 1'b1) @(negedge clk);
    check(rd_valid, 1'b1);
    d0 = rd_data0;
    d1 = rd_data1;
    @(negedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_plain;
    check(lnk.latency_select_pin, 1'b1);
    wr(20'h00003, 36'h123456789, 36'hABCDEF012, 4'hF, 4'hF);
    rd(20'h00003);
    check(d0, 36'h123456789);
    check(d1, 36'hABCDEF012);
    $display("t_plain done");
  endtask

  task automatic t_bytes;
    e0 = merge(36'h123456789, 36'h0F0F0F0F0, 4'h5);
    e1 = merge(36'hABCDEF012, 36'hF0F0F0F0F, 4'hA);
    wr(20'h00003, 36'h0F0F0F0F0, 36'hF0F0F0F0F, 4'h5, 4'hA);
    rd(20'h00003);
    check(d0, e0);
    check(d1, e1);
    $display("t_bytes done");
  endtask

  task automatic t_conc;
    fork
      wr(20'h00005, 36'h111111111, 36'h222222222, 4'hF, 4'hF);
      rd(20'h00003);
    join
    check(d0, e0);
    check(d1, e1);
    rd(20'h00005);
    check(d0, 36'h111111111);
    check(d1, 36'h222222222);
    $display("t_conc done");
  endtask

  task automatic t_idle;
    snap = n_vld;
    repeat (64) @(negedge clk);
    check(n_vld, snap);
    check(n_wr, 3);
    check(n_rd, 4);
    $display("t_idle done");
  endtask

  task automatic t_short;
    lat_cfg = 1'b0;
    rst_b   = 1'b0;
    repeat (3) @(negedge clk);
    check(lnk.rd_sel_n, 1'b1);
    rst_b = 1'b1;
    @(negedge clk);
    check(lnk.latency_select_pin, 1'b0);
    // Read slot comes first, so the write lands while the read burst is out
    fork
      wr(20'h00003, 36'h333333333, 36'h444444444, 4'hF, 4'hF);
      rd(20'h00003);
    join
    check(d0, 36'h333333333);
    check(d1, 36'h444444444);
    rd(20'h00005);
    check(d0, 36'h111111111);
    check(d1, 36'h222222222);
    $display("t_short done");
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    rst_b    = 1'b0;
    lat_cfg  = 1'b1;
    rd_req   = 1'b0;
    rd_addr  = 20'h00000;
    wr_req   = 1'b0;
    wr_addr  = 20'h00000;
    wr_data0 = 36'h000000000;
    wr_data1 = 36'h000000000;
    wr_be0   = 4'h0;
    wr_be1   = 4'h0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_plain();
    t_bytes();
    t_conc();
    t_idle();
    t_short();
    summarize();
  end
endmodule
